// ---- include/nirr_pkg.sv ----
package nirr_pkg;
  // request payload
  localparam logic [7:0] NIRR_CMD_CODE = 8'h78;
  localparam logic [23:0] NIRR_CMD_PAD = 24'h000000;
  // reply codes in byte 0 of word 0
  localparam logic [7:0] NIRR_ACC_CODE = 8'h02;
  localparam logic [7:0] NIRR_RJT_CODE = 8'h01;
  // data format codes
  localparam logic [7:0] NIRR_FMT_COMMON = 8'h00;
  localparam logic [7:0] NIRR_FMT_TOPO = 8'hdf;
  // length fields, in bytes
  localparam logic [7:0] NIRR_COMMON_LEN = 8'h10;
  localparam logic [7:0] NIRR_TOPO_LEN = 8'h34;
  localparam logic [7:0] NIRR_SPEC_MAX = 8'hfc;
  // word positions in the accept payload
  localparam logic [6:0] NIRR_HDR_WORDS = 7'h02;
  localparam logic [6:0] NIRR_SPEC_WORD = 7'h06;
  // fabric controller address
  localparam logic [23:0] NIRR_FABRIC_ID = 24'hfffffd;
  // physical interface type codes
  localparam logic [1:0] NIRR_PHY_NONE = 2'h0;
  localparam logic [1:0] NIRR_PHY_FC = 2'h1;
  localparam logic [1:0] NIRR_PHY_ENET = 2'h2;
  typedef enum logic [1:0] {
    NIRR_ST_CMD = 2'b00,
    NIRR_ST_FMT = 2'b01,
    NIRR_ST_DRAIN = 2'b10,
    NIRR_ST_REPLY = 2'b11
  } nirr_state_t;
endpackage

// ---- hdl/nirr_spec_store.sv ----
`timescale 1ns/1ps
`default_nettype none
// two banks of specific data words: bank 0 topology, bank 1 upper protocol
module nirr_spec_store #(
  parameter int DEPTH = 64,
  parameter int AW = 6,
  parameter int DW = 32
) (
  // clock
  input wire logic core_clk,
  // write side
  input wire logic wr_en,
  input wire logic wr_sel,
  input wire logic [AW-1:0] wr_idx,
  input wire logic [DW-1:0] wr_data,
  // read side, combinational
  input wire logic rd_sel,
  input wire logic [AW-1:0] rd_idx,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem [0:2*DEPTH-1];

  // no reset: contents are loaded by the owner before use
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[{wr_sel, wr_idx}] <= wr_data;
    end
  end

  // async read keeps the reply pipeline one stage deep
  assign rd_data = mem[{rd_sel, rd_idx}];
endmodule
`default_nettype wire

// ---- hdl/nirr_responder.sv ----
`timescale 1ns/1ps
`default_nettype none
module nirr_responder
  import nirr_pkg::*;
#(
  parameter logic [7:0] RJT_NOT_SUPP = 8'h0b,
  parameter logic [7:0] RJT_UNABLE = 8'h09,
  parameter logic [7:0] EXPL_NO_DATA = 8'h2a,
  parameter logic [7:0] EXPL_NONE = 8'h00
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // request stream
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [31:0] req_data,
  input wire logic req_last,
  input wire logic [23:0] req_did,
  // policy
  input wire logic svc_enable,
  input wire logic reject_unsup,
  input wire logic topo_enable,
  input wire logic ulp_enable,
  input wire logic [7:0] ulp_fmt,
  input wire logic [5:0] ulp_words,
  input wire logic [1:0] phy_type,
  // identity
  input wire logic [63:0] port_name,
  input wire logic [63:0] node_name,
  input wire logic [63:0] sw_port_name,
  input wire logic [63:0] sw_node_name,
  // specific data loading
  input wire logic spec_wr,
  input wire logic spec_wr_ulp,
  input wire logic [5:0] spec_wr_idx,
  input wire logic [31:0] spec_wr_data,
  // reply stream
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [31:0] rsp_data,
  output logic rsp_last,
  output logic rsp_accept
);
  nirr_state_t st_r, st_nxt;
  logic cmd_ok_r, fab_r, acc_r;
  logic [7:0] fmt_r, slen_r, reason_r, expl_r;
  logic [6:0] nwords_r, w_r, out_idx_r;
  logic [31:0] word_c, spec_rd;
  logic [63:0] pname_c, nname_c;
  logic take, out_free, emit, emit_last;

  // handshake qualifiers shared by the sequencer and output stage
  assign take = req_valid && req_ready;
  assign out_free = !rsp_valid || rsp_ready;
  assign emit = (st_r == NIRR_ST_REPLY) && out_free;
  assign emit_last = emit && (w_r == nwords_r - 7'h01);

  // request sequencing
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      NIRR_ST_CMD: begin
        if (take) begin
          st_nxt = req_last ? NIRR_ST_REPLY : NIRR_ST_FMT;
        end
      end
      NIRR_ST_FMT: begin
        if (take) begin
          st_nxt = req_last ? NIRR_ST_REPLY : NIRR_ST_DRAIN;
        end
      end
      NIRR_ST_DRAIN: begin
        if (take && req_last) begin
          st_nxt = NIRR_ST_REPLY;
        end
      end
      NIRR_ST_REPLY: begin
        if (emit_last) begin
          st_nxt = NIRR_ST_CMD;
        end
      end
      default: st_nxt = NIRR_ST_CMD;
    endcase
  end

  // ready drops with the reply so no request overlaps its answer
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_r <= NIRR_ST_CMD;
      req_ready <= 1'b0;
    end else begin
      st_r <= st_nxt;
      req_ready <= (st_nxt != NIRR_ST_REPLY);
    end
  end

  // word 0: command check and destination capture
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cmd_ok_r <= 1'b0;
      fab_r <= 1'b0;
    end else if (take && st_r == NIRR_ST_CMD) begin
      cmd_ok_r <= svc_enable &&
        (req_data == {NIRR_CMD_CODE, NIRR_CMD_PAD});
      fab_r <= (req_did == NIRR_FABRIC_ID);
    end
  end

  // reply decision, made once per request
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      acc_r <= 1'b0;
      fmt_r <= NIRR_FMT_COMMON;
      slen_r <= 8'h00;
      nwords_r <= NIRR_HDR_WORDS;
      reason_r <= 8'h00;
      expl_r <= 8'h00;
    end else if (take && st_r == NIRR_ST_CMD && req_last) begin
      // payload too short to carry a format word
      acc_r <= 1'b0;
      nwords_r <= NIRR_HDR_WORDS;
      expl_r <= EXPL_NONE;
      reason_r <= (svc_enable &&
        req_data == {NIRR_CMD_CODE, NIRR_CMD_PAD}) ?
        RJT_UNABLE : RJT_NOT_SUPP;
    end else if (take && st_r == NIRR_ST_FMT) begin
      acc_r <= 1'b1;
      expl_r <= EXPL_NONE;
      reason_r <= 8'h00;
      nwords_r <= NIRR_SPEC_WORD;
      fmt_r <= NIRR_FMT_COMMON;
      slen_r <= 8'h00;
      if (!cmd_ok_r) begin
        acc_r <= 1'b0;
        reason_r <= RJT_NOT_SUPP;
        nwords_r <= NIRR_HDR_WORDS;
      end else if (req_data[31:24] == NIRR_FMT_COMMON) begin
        fmt_r <= NIRR_FMT_COMMON;
      end else if (req_data[31:24] == NIRR_FMT_TOPO && topo_enable) begin
        fmt_r <= NIRR_FMT_TOPO;
        slen_r <= NIRR_TOPO_LEN;
        nwords_r <= NIRR_SPEC_WORD + 7'(NIRR_TOPO_LEN >> 2);
      end else if (ulp_enable && req_data[31:24] == ulp_fmt &&
                   ulp_fmt != NIRR_FMT_COMMON &&
                   ulp_fmt != NIRR_FMT_TOPO) begin
        fmt_r <= ulp_fmt;
        slen_r <= {ulp_words, 2'b00};
        nwords_r <= NIRR_SPEC_WORD + {1'b0, ulp_words};
      end else if (reject_unsup) begin
        acc_r <= 1'b0;
        reason_r <= RJT_UNABLE;
        expl_r <= EXPL_NO_DATA;
        nwords_r <= NIRR_HDR_WORDS;
      end
    end
  end

  // names follow the addressed port or the switch
  assign pname_c = fab_r ? sw_port_name : port_name;
  assign nname_c = fab_r ? sw_node_name : node_name;

  nirr_spec_store #(
    .DEPTH(64),
    .AW(6),
    .DW(32)
  ) u_store (
    .core_clk(core_clk),
    .wr_en(spec_wr),
    .wr_sel(spec_wr_ulp),
    .wr_idx(spec_wr_idx),
    .wr_data(spec_wr_data),
    .rd_sel(fmt_r != NIRR_FMT_TOPO),
    .rd_idx(6'(w_r - NIRR_SPEC_WORD)),
    .rd_data(spec_rd)
  );

  // reply word selection
  always_comb begin
    case (w_r)
      7'h00: word_c = {acc_r ? NIRR_ACC_CODE : NIRR_RJT_CODE,
                       24'h000000};
      7'h01: word_c = acc_r ?
        {fmt_r, NIRR_COMMON_LEN, phy_type, 6'h00, slen_r} :
        {8'h00, reason_r, expl_r, 8'h00};
      7'h02: word_c = pname_c[63:32];
      7'h03: word_c = pname_c[31:0];
      7'h04: word_c = nname_c[63:32];
      7'h05: word_c = nname_c[31:0];
      default: word_c = spec_rd;
    endcase
  end

  // reply word counter
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      w_r <= 7'h00;
    end else if (emit_last) begin
      w_r <= 7'h00;
    end else if (emit) begin
      w_r <= w_r + 7'h01;
    end
  end

  // output register; holds under back-pressure
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rsp_valid <= 1'b0;
      rsp_data <= 32'h00000000;
      rsp_last <= 1'b0;
      rsp_accept <= 1'b0;
      out_idx_r <= 7'h00;
    end else if (emit) begin
      rsp_valid <= 1'b1;
      rsp_data <= word_c;
      rsp_last <= emit_last;
      rsp_accept <= acc_r;
      out_idx_r <= w_r;
    end else if (rsp_ready) begin
      rsp_valid <= 1'b0;
    end
  end

  // checks on the reply stream
  chk_acc_header: assert property (@(posedge core_clk)
    disable iff (reset)
    rsp_valid && rsp_accept && out_idx_r == 7'h00 |->
    rsp_data == 32'h02000000) else $error("bad accept word 0");
  chk_common_len: assert property (@(posedge core_clk)
    disable iff (reset)
    rsp_valid && rsp_accept && out_idx_r == 7'h01 |->
    rsp_data[23:16] == 8'h10) else $error("bad common length");
  chk_phy_reserved: assert property (@(posedge core_clk)
    disable iff (reset)
    rsp_valid && rsp_accept && out_idx_r == 7'h01 |->
    rsp_data[13:8] == 6'h00) else $error("reserved phy bits set");
  chk_spec_len: assert property (@(posedge core_clk)
    disable iff (reset)
    rsp_valid && rsp_accept && out_idx_r == 7'h01 |->
    rsp_data[1:0] == 2'b00 && rsp_data[7:0] <= 8'hfc)
    else $error("bad specific length");
  chk_topo_len: assert property (@(posedge core_clk)
    disable iff (reset)
    rsp_valid && rsp_accept && out_idx_r == 7'h01 &&
    rsp_data[31:24] == 8'hdf |-> rsp_data[7:0] == 8'h34)
    else $error("topology length not 52");
  chk_common_only: assert property (@(posedge core_clk)
    disable iff (reset)
    rsp_valid && rsp_accept && out_idx_r == 7'h01 &&
    rsp_data[31:24] == 8'h00 |-> rsp_data[7:0] == 8'h00)
    else $error("common-only accept has specific data");
  chk_total_len: assert property (@(posedge core_clk)
    disable iff (reset)
    rsp_valid && rsp_accept && rsp_last |->
    ({out_idx_r, 2'b00} + 9'h004) == (9'h008 + 9'(slen_r) + 9'h010))
    else $error("accept length mismatch");
  chk_not_supported: assert property (@(posedge core_clk)
    disable iff (reset)
    rsp_valid && !rsp_accept && out_idx_r == 7'h01 && !cmd_ok_r |->
    rsp_data[23:16] == RJT_NOT_SUPP) else $error("wrong reject code");
  chk_fabric_name: assert property (@(posedge core_clk)
    disable iff (reset)
    rsp_valid && rsp_accept && out_idx_r == 7'h02 |->
    rsp_data == (fab_r ? sw_port_name[63:32] : port_name[63:32]))
    else $error("wrong port name");
  chk_stall_hold: assert property (@(posedge core_clk) disable iff (reset)
    rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data) &&
    $stable(rsp_last)) else $error("reply changed under stall");
endmodule
`default_nettype wire

// ---- test/nirr_sink.sv ----
`timescale 1ns/1ps
`default_nettype none
// reply sink standing in for the requester; may stall every other cycle
module nirr_sink (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // reply stream
  input wire logic rsp_valid,
  output logic rsp_ready,
  input wire logic [31:0] rsp_data,
  input wire logic rsp_last,
  input wire logic rsp_accept,
  // bench control
  input wire logic stall,
  input wire logic clr,
  output logic done
);
  logic tog_r;
  logic acc;
  logic [31:0] words [0:127];
  int n;
  // toggling ready forces the block to hold a word it offers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) tog_r <= 1'b0;
    else tog_r <= ~tog_r;
  end
  assign rsp_ready = stall ? tog_r : 1'b1;
  // capture each word taken; longest reply is 69 words, so room for 128
  always_ff @(posedge core_clk) begin
    if (clr) begin
      n <= 0;
      done <= 1'b0;
    end else if (rsp_valid && rsp_ready && n < 128) begin
      words[n] <= rsp_data;
      n <= n + 1;
      done <= rsp_last;
      acc <= rsp_accept;
    end
  end
endmodule
`default_nettype wire

// ---- test/tb_node_ident_request_responder.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_node_ident_request_responder;
  import nirr_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic req_valid, req_last, svc_enable, reject_unsup, topo_enable;
  logic ulp_enable, spec_wr, spec_wr_ulp, req_ready, rsp_valid, rsp_ready;
  logic rsp_last, rsp_accept, stall, clr, done;
  logic [31:0] req_data, spec_wr_data, rsp_data;
  logic [23:0] req_did;
  logic [7:0] ulp_fmt;
  logic [5:0] ulp_words, spec_wr_idx;
  logic [1:0] phy_type;
  logic [63:0] port_name, node_name, sw_port_name, sw_node_name;
  int fail_count = 0;
  int cmp_count = 0;
  // request length in words: 1 stops at word 0, 3 adds a drained word
  int shape = 2;
  always #10 core_clk = ~core_clk;
  nirr_responder dut (.core_clk, .reset, .req_valid, .req_ready, .req_data,
    .req_last, .req_did, .svc_enable, .reject_unsup, .topo_enable,
    .ulp_enable, .ulp_fmt, .ulp_words, .phy_type, .port_name, .node_name,
    .sw_port_name, .sw_node_name, .spec_wr, .spec_wr_ulp, .spec_wr_idx,
    .spec_wr_data, .rsp_valid, .rsp_ready, .rsp_data, .rsp_last,
    .rsp_accept);
  nirr_sink snk (.core_clk, .reset, .rsp_valid, .rsp_ready, .rsp_data,
    .rsp_last, .rsp_accept, .stall, .clr, .done);
  // recognisable word per bank and index
  function automatic logic [31:0] spat(input logic u, input int k);
    return {7'h2b, u, 18'h0, k[5:0]};
  endfunction
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  // one request, then the whole reply judged word by word
  task automatic run(string nm, logic [31:0] w0, logic [7:0] fmt,
      logic [23:0] did, logic acc, logic [31:0] w1, logic u);
    logic [63:0] pn, nn;
    int k;
    clr = 1'b1;
    @(negedge core_clk);
    clr = 1'b0;
    for (k = 0; k < 50 && req_ready !== 1'b1; k++) @(negedge core_clk);
    if (req_ready !== 1'b1) begin
      fail_count++;
      test_done();
    end
    req_valid = 1'b1;
    req_data = w0;
    req_did = did;
    req_last = (shape == 1);
    @(negedge core_clk);
    if (shape > 1) begin
      req_data = {fmt, 24'h000000};
      req_last = (shape == 2);
      @(negedge core_clk);
    end
    if (shape > 2) begin
      req_data = 32'h5a5a5a5a;
      req_last = 1'b1;
      @(negedge core_clk);
    end
    req_valid = 1'b0;
    req_last = 1'b0;
    req_data = ~req_data;
    req_did = ~did;
    for (k = 0; k < 300 && done !== 1'b1; k++) @(negedge core_clk);
    if (done !== 1'b1) begin
      fail_count++;
      test_done();
    end
    pn = (did == NIRR_FABRIC_ID) ? sw_port_name : port_name;
    nn = (did == NIRR_FABRIC_ID) ? sw_node_name : node_name;
    chk("accept", {31'h0, acc}, {31'h0, snk.acc});
    chk("w1", w1, snk.words[1]);
    if (acc) begin
      chk("count", 6 + w1[7:0] / 4, snk.n);
      chk("w0", 32'h02000000, snk.words[0]);
      chk("pn hi", pn[63:32], snk.words[2]);
      chk("pn lo", pn[31:0], snk.words[3]);
      chk("nn hi", nn[63:32], snk.words[4]);
      chk("nn lo", nn[31:0], snk.words[5]);
      for (k = 0; k < w1[7:0] / 4; k++)
        chk("spec", spat(u, k), snk.words[6 + k]);
    end else begin
      chk("count", 2, snk.n);
      chk("w0", 32'h01000000, snk.words[0]);
    end
    $display("end of %s", nm);
  endtask
  task automatic t_common();
    phy_type = 2'b10;
    run("common", 32'h78000000, 8'h00, 24'h010203, 1, 32'h00108000, 0);
  endtask
  task automatic t_topo();
    phy_type = 2'b01;
    stall = 1'b1;
    run("topo", 32'h78000000, 8'hdf, 24'h010203, 1, 32'hdf104034, 0);
    stall = 1'b0;
  endtask
  task automatic t_ulp();
    run("ulp", 32'h78000000, 8'he5, 24'h0a0b0c, 1, 32'he51040fc, 1);
  endtask
  task automatic t_unsup();
    reject_unsup = 1'b1;
    run("unsup rej", 32'h78000000, 8'h33, 24'h010203, 0,
      32'h00092a00, 0);
    topo_enable = 1'b0;
    run("topo off", 32'h78000000, 8'hdf, 24'h010203, 0,
      32'h00092a00, 0);
    run("retry", 32'h78000000, 8'h00, 24'h010203, 1, 32'h00104000, 0);
    reject_unsup = 1'b0;
    run("unsup acc", 32'h78000000, 8'h34, 24'h010203, 1,
      32'h00104000, 0);
  endtask
  task automatic t_notsupp();
    svc_enable = 1'b0;
    run("svc off", 32'h78000000, 8'h00, 24'h010203, 0,
      32'h000b0000, 0);
    svc_enable = 1'b1;
    run("bad cmd", 32'h78000001, 8'h00, 24'h010203, 0,
      32'h000b0000, 0);
  endtask
  // short request is refused; a longer one is drained and still answered
  task automatic t_shape();
    shape = 1;
    run("one word", 32'h78000000, 8'h00, 24'h010203, 0,
      32'h00090000, 0);
    shape = 3;
    run("three words", 32'h78000000, 8'hdf, 24'h010203, 1,
      32'hdf104034, 0);
    shape = 2;
  endtask
  task automatic t_fabric();
    run("fabric", 32'h78000000, 8'h00, 24'hfffffd, 1, 32'h00104000, 0);
  endtask
  initial begin
    {req_valid, req_last, spec_wr, spec_wr_ulp, stall, clr} = '0;
    {svc_enable, topo_enable, ulp_enable, reject_unsup} = 4'hf;
    {req_data, spec_wr_data, req_did, spec_wr_idx} = '0;
    {ulp_fmt, ulp_words, phy_type} = {8'he5, 6'h3f, 2'h0};
    {port_name, node_name} = {64'h1020304050607080, 64'h1122334455667788};
    {sw_port_name, sw_node_name} = {64'ha1a2a3a4a5a6a7a8, 64'hb1b2b3b4b5b6b7b8};
    repeat (10) @(negedge core_clk);
    reset = 1'b0;
    // fill both banks completely
    for (int i = 0; i < 128; i++) begin
      spec_wr = 1'b1;
      spec_wr_ulp = i[6];
      spec_wr_idx = i[5:0];
      spec_wr_data = spat(i[6], i[5:0]);
      @(negedge core_clk);
    end
    spec_wr = 1'b0;
    t_common();
    t_topo();
    t_ulp();
    t_fabric();
    t_notsupp();
    t_shape();
    t_unsup();
    test_done();
  end
endmodule
`default_nettype wire
